// ---- logic/str_pkg.sv ----
// Package of constants for the segmented data-object retrieval block.
// Assumes one clock domain and a synchronous active-high reset.
package str_pkg;
  localparam int ADDR_W = 16;
  localparam int LEN_W = 16;
  localparam int FILE_W = 8;
  localparam int TAG_W = 8;
  localparam int DIR_N = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int WORD_W = 10;
  // Stream word fields: last flag, status flag, byte.
  localparam int BIT_LAST = 9;
  localparam int BIT_SW = 8;
  // Command kinds seen on the command port.
  localparam logic [2:0] CMD_FIRST = 3'h0;
  localparam logic [2:0] CMD_NEXT = 3'h1;
  localparam logic [2:0] CMD_RETX = 3'h2;
  localparam logic [2:0] CMD_SEL = 3'h3;
  localparam logic [2:0] CMD_TAG = 3'h4;
  localparam logic [2:0] CMD_OK = 3'h5;
  localparam logic [2:0] CMD_ERR = 3'h6;
  // Status words.
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_MORE = 16'h62f1;
  localparam logic [15:0] SW_MORE_PRO = 16'h62f2;
  localparam logic [15:0] SW_SEC = 16'h6982;
  localparam logic [15:0] SW_NOT_FOUND = 16'h6a88;
  localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
  localparam logic [15:0] SW_NO_TAG = 16'h6a88;
  localparam logic [15:0] SW_NO_RETX = 16'h6985;
  localparam logic [LEN_W-1:0] LE_MAX = 16'h0100;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RD = 5'b00010,
    ST_PUSH = 5'b00100,
    ST_SW1 = 5'b01000,
    ST_SW2 = 5'b10000
  } str_state_t;
endpackage

// ---- logic/str_fifo.sv ----
// Small first-in first-out buffer held in flip-flops.
// Assumes both sides share clk_i; a word moves when valid and ready meet.
`timescale 1ns/1ps
module str_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  // Full and empty come from the true count, never from guesses.
  assign in_ready_o = (count != FULL);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage writes need no reset; only pointers and count carry state.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (srst_i)
    count <= FULL) else $error("FIFO count beyond depth.");
endmodule

// ---- logic/str_dir.sv ----
// Directory of data objects: file, tag, start address and full TLV length.
// Assumes the loader writes entries while no retrieval is running.
`timescale 1ns/1ps
module str_dir
  import str_pkg::*;
#(
  parameter int N = 4
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_i,
  input wire logic [$clog2(N)-1:0] wr_idx_i,
  input wire logic wr_valid_i,
  input wire logic [FILE_W-1:0] wr_file_i,
  input wire logic [TAG_W-1:0] wr_tag_i,
  input wire logic [ADDR_W-1:0] wr_start_i,
  input wire logic [LEN_W-1:0] wr_len_i,
  input wire logic [FILE_W-1:0] file_i,
  input wire logic [TAG_W-1:0] tag_i,
  output logic hit_o,
  output logic [ADDR_W-1:0] start_o,
  output logic [LEN_W-1:0] len_o
);
  logic [N-1:0] ent_valid;
  logic [FILE_W-1:0] ent_file [N];
  logic [TAG_W-1:0] ent_tag [N];
  logic [ADDR_W-1:0] ent_start [N];
  logic [LEN_W-1:0] ent_len [N];
  logic [N-1:0] match;

  // Entries are loaded one at a time by index.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ent_valid <= '0;
    end else if (wr_i) begin
      ent_valid[wr_idx_i] <= wr_valid_i;
      ent_file[wr_idx_i] <= wr_file_i;
      ent_tag[wr_idx_i] <= wr_tag_i;
      ent_start[wr_idx_i] <= wr_start_i;
      ent_len[wr_idx_i] <= wr_len_i;
    end
  end

  // One comparator per entry.
  for (genvar g = 0; g < N; g++) begin : g_match
    assign match[g] = ent_valid[g] && (ent_file[g] == file_i) &&
                      (ent_tag[g] == tag_i);
  end

  // Lowest matching entry wins if the loader duplicated a tag.
  always_comb begin
    hit_o = 1'b0;
    start_o = '0;
    len_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (match[i]) begin
        hit_o = 1'b1;
        start_o = ent_start[i];
        len_o = ent_len[i];
      end
    end
  end
endmodule

// ---- logic/str_top.sv ----
// Card-side retrieval engine for BER-TLV objects, whole or in segments.
// Assumes a command decoder on clk_i, a byte memory with one-cycle read
// latency, and a response sink that may stall.
`timescale 1ns/1ps
module str_top
  import str_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [2:0] cmd_kind_i,
  input wire logic [TAG_W-1:0] cmd_tag_i,
  input wire logic [FILE_W-1:0] cmd_file_i,
  input wire logic [7:0] cmd_le_i,
  input wire logic access_ok_i,
  input wire logic proactive_i,
  input wire logic dir_wr_i,
  input wire logic [$clog2(DIR_N)-1:0] dir_idx_i,
  input wire logic dir_valid_i,
  input wire logic [FILE_W-1:0] dir_file_i,
  input wire logic [TAG_W-1:0] dir_tag_i,
  input wire logic [ADDR_W-1:0] dir_start_i,
  input wire logic [LEN_W-1:0] dir_len_i,
  output logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [7:0] mem_data_i,
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [7:0] rsp_data_o,
  output logic rsp_sw_o,
  output logic rsp_last_o
);
  str_state_t state, next_state;
  // Transfer context.
  logic [FILE_W-1:0] cur_file;
  logic [TAG_W-1:0] tag_ptr;
  logic tag_valid, done, last_ok;
  logic [ADDR_W-1:0] obj_start, prev_addr;
  logic [LEN_W-1:0] obj_len, offset, prev_len;
  logic [15:0] prev_sw;
  // Response in progress.
  logic [LEN_W-1:0] cnt;
  logic [15:0] cur_sw;
  // Decision of the command being taken.
  logic cmd_fire, is_get, dec_ok, dir_hit;
  logic [15:0] dec_sw;
  logic [LEN_W-1:0] dec_len, avail, le_full, dir_len;
  logic [ADDR_W-1:0] dec_addr, dir_start;
  // Buffer hookup.
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [WORD_W-1:0] fifo_in_data, fifo_out_data;

  assign cmd_fire = cmd_valid_i && cmd_ready_o;
  assign is_get = (cmd_kind_i == CMD_FIRST) || (cmd_kind_i == CMD_NEXT) ||
                  (cmd_kind_i == CMD_RETX);

  // Lookup always uses the current file, so a stale file can never match.
  str_dir #(
    .N(DIR_N)
  ) u_dir (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .wr_i(dir_wr_i),
    .wr_idx_i(dir_idx_i),
    .wr_valid_i(dir_valid_i),
    .wr_file_i(dir_file_i),
    .wr_tag_i(dir_tag_i),
    .wr_start_i(dir_start_i),
    .wr_len_i(dir_len_i),
    .file_i(cur_file),
    .tag_i(cmd_tag_i),
    .hit_o(dir_hit),
    .start_o(dir_start),
    .len_o(dir_len)
  );

  // Decide status, segment length and start address in the taking cycle.
  always_comb begin
    le_full = (cmd_le_i == 8'h00) ? LE_MAX : {8'h00, cmd_le_i};
    dec_ok = 1'b0;
    dec_sw = SW_SEC;
    dec_len = '0;
    dec_addr = '0;
    avail = '0;
    if (!access_ok_i) begin
      dec_sw = SW_SEC;
    end else begin
      case (cmd_kind_i)
        CMD_FIRST: begin
          if (!dir_hit) begin
            dec_sw = SW_NOT_FOUND;
          end else begin
            dec_ok = 1'b1;
            avail = dir_len;
            dec_addr = dir_start;
          end
        end
        CMD_NEXT: begin
          if (!tag_valid) begin
            dec_sw = SW_NO_TAG;
          end else if (done) begin
            dec_sw = SW_BAD_P1P2;
          end else begin
            dec_ok = 1'b1;
            avail = obj_len - offset;
            dec_addr = obj_start + offset;
          end
        end
        CMD_RETX: begin
          if (!last_ok) begin
            dec_sw = SW_NO_RETX;
          end else begin
            dec_ok = 1'b1;
            dec_sw = prev_sw;
            dec_len = prev_len;
            dec_addr = prev_addr;
          end
        end
        default: begin
          dec_sw = SW_OK;
        end
      endcase
    end
    // Segment is clipped by the expected length; leftovers signal more.
    if (dec_ok && (cmd_kind_i != CMD_RETX)) begin
      if (avail > le_full) begin
        dec_len = le_full;
        dec_sw = proactive_i ? SW_MORE_PRO : SW_MORE;
      end else begin
        dec_len = avail;
        dec_sw = SW_OK;
      end
    end
  end

  // Current file and tag pointer validity; selection moves both, a tag change only clears validity, a first block sets it only on success.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cur_file <= '0;
      tag_ptr <= '0;
      tag_valid <= 1'b0;
    end else if (cmd_fire) begin
      if (cmd_kind_i == CMD_SEL) begin
        cur_file <= cmd_file_i;
        tag_valid <= 1'b0;
      end else if (cmd_kind_i == CMD_TAG) begin
        tag_valid <= 1'b0;
      end else if (cmd_kind_i == CMD_FIRST && dec_ok) begin
        tag_ptr <= cmd_tag_i;
        tag_valid <= 1'b1;
      end
    end
  end

  // Object window and offset; an error leaves all of it alone.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      obj_start <= '0;
      obj_len <= '0;
      offset <= '0;
      done <= 1'b0;
    end else if (cmd_fire && dec_ok) begin
      if (cmd_kind_i == CMD_FIRST) begin
        obj_start <= dir_start;
        obj_len <= dir_len;
        offset <= dec_len;
        done <= (dec_len == avail);
      end else if (cmd_kind_i == CMD_NEXT) begin
        offset <= offset + dec_len;
        done <= (dec_len == avail);
      end
    end
  end

  // Error history and the last answer kept for retransmission.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      last_ok <= 1'b0;
      prev_addr <= '0;
      prev_len <= '0;
      prev_sw <= SW_OK;
    end else if (cmd_fire) begin
      if (is_get) begin
        last_ok <= dec_ok;
        if (dec_ok) begin
          prev_addr <= dec_addr;
          prev_len <= dec_len;
          prev_sw <= dec_sw;
        end
      end else begin
        last_ok <= (cmd_kind_i != CMD_ERR);
      end
    end
  end

  // Sequencer: read a byte, push it, repeat, then push both status bytes.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmd_fire && is_get) begin
          next_state = (dec_ok && dec_len != '0) ? ST_RD : ST_SW1;
        end
      end
      ST_RD: next_state = ST_PUSH;
      ST_PUSH: begin
        if (fifo_in_ready) begin
          next_state = (cnt == LEN_W'(1)) ? ST_SW1 : ST_RD;
        end
      end
      ST_SW1: if (fifo_in_ready) next_state = ST_SW2;
      ST_SW2: if (fifo_in_ready) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // State and the ready flag both come from the next state.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      cmd_ready_o <= 1'b1;
    end else begin
      state <= next_state;
      cmd_ready_o <= (next_state == ST_IDLE);
    end
  end

  // Byte counter, memory address and status of the running response.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt <= '0;
      mem_addr_o <= '0;
      cur_sw <= SW_OK;
    end else if (state == ST_IDLE && cmd_fire && is_get) begin
      cnt <= dec_len;
      mem_addr_o <= dec_addr;
      cur_sw <= dec_sw;
    end else if (state == ST_PUSH && fifo_in_ready) begin
      cnt <= cnt - 1'b1;
      mem_addr_o <= mem_addr_o + 1'b1;
    end
  end

  // The buffer lets the sink stall without stopping memory fetch early.
  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    case (state)
      ST_PUSH: begin
        fifo_in_valid = 1'b1;
        fifo_in_data = {2'b00, mem_data_i};
      end
      ST_SW1: begin
        fifo_in_valid = 1'b1;
        fifo_in_data = {2'b01, cur_sw[15:8]};
      end
      ST_SW2: begin
        fifo_in_valid = 1'b1;
        fifo_in_data = {2'b11, cur_sw[7:0]};
      end
      default: fifo_in_data = '0;
    endcase
  end

  str_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // Output register so every response pin comes from a flip-flop.
  assign fifo_out_ready = !rsp_valid_o || rsp_ready_i;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
      rsp_sw_o <= 1'b0;
      rsp_last_o <= 1'b0;
    end else if (fifo_out_ready) begin
      rsp_valid_o <= fifo_out_valid;
      rsp_data_o <= fifo_out_data[7:0];
      rsp_sw_o <= fifo_out_data[BIT_SW];
      rsp_last_o <= fifo_out_data[BIT_LAST];
    end
  end

  sel_undef_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_fire && cmd_kind_i == CMD_SEL |=> !tag_valid)
    else $error("Selection left the tag pointer defined.");
  keep_ctx_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_fire && cmd_kind_i == CMD_OK |=>
      $stable(tag_valid) && $stable(offset) && $stable(done))
    else $error("Neutral command disturbed the transfer.");
  abort_tag_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_fire && cmd_kind_i == CMD_TAG |=> !tag_valid)
    else $error("Tag change did not abort the transfer.");
  first_load_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_fire && cmd_kind_i == CMD_FIRST && dec_ok |=>
      tag_valid && tag_ptr == $past(cmd_tag_i) && offset == $past(dec_len))
    else $error("First block did not restart the object.");
  err_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_fire && is_get && !dec_ok |=>
      $stable(offset) && $stable(tag_ptr) && $stable(obj_len))
    else $error("Error status changed the context.");
  retx_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_fire && cmd_kind_i == CMD_RETX && access_ok_i && !last_ok |->
      dec_sw == SW_NO_RETX)
    else $error("Retransmit accepted after an error.");
  more_sw_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_fire && dec_ok && cmd_kind_i != CMD_RETX && !proactive_i &&
      dec_len < avail |-> dec_sw == SW_MORE)
    else $error("More data without the more-data status.");
  done_rej_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_fire && cmd_kind_i == CMD_NEXT && access_ok_i && tag_valid && done
      |-> !dec_ok && dec_sw == SW_BAD_P1P2)
    else $error("Next block on a finished object not refused.");
  seg_fit_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_fire && dec_ok && cmd_kind_i != CMD_RETX |-> dec_len <= le_full)
    else $error("Segment longer than the expected length.");
  retx_same_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_fire && cmd_kind_i == CMD_RETX && dec_ok |=>
      $stable(offset) && cur_sw == $past(prev_sw))
    else $error("Retransmit moved the offset or changed status.");
endmodule

// ---- tb/str_env_model.sv ----
// Far-side model: byte memory with one-cycle read and a stalling sink.
// Assumes the bench loads mem before the first retrieval starts.
`timescale 1ns/1ps
module str_env_model
  import str_pkg::*;
(
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic [ADDR_W-1:0] mem_addr_i,
  output logic [7:0] mem_data_o,
  output logic rsp_ready_o
);
  logic [7:0] mem [0:255];

  // Synchronous read, so the byte for an address shows one clock later.
  always @(posedge clk_i) begin
    mem_data_o <= mem[mem_addr_i[7:0]];
  end

  // Random stalls press on the buffer; stall_i keeps it full on purpose.
  always @(negedge clk_i) begin
    rsp_ready_o <= !stall_i && ($urandom_range(3, 0) != 0);
  end
endmodule

// ---- tb/test_str_top.sv ----
// Self-checking bench for the retrieval engine.
// Assumes str_env_model answers reads one clock late and stalls the sink.
`timescale 1ns/1ps
module test_str_top
  import str_pkg::*;
;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic access_ok_i = 1'b0;
  logic proactive_i = 1'b0;
  logic dir_wr_i = 1'b0;
  logic dir_valid_i = 1'b1;
  logic stall = 1'b0;
  logic [2:0] cmd_kind_i = 3'h0;
  logic [7:0] cmd_tag_i = 8'h00;
  logic [7:0] cmd_file_i = 8'h00;
  logic [7:0] cmd_le_i = 8'h00;
  logic [1:0] dir_idx_i = 2'h0;
  logic [7:0] dir_file_i = 8'h00;
  logic [7:0] dir_tag_i = 8'h00;
  logic [15:0] dir_start_i = 16'h0000;
  logic [15:0] dir_len_i = 16'h0000;
  logic cmd_ready_o;
  logic [15:0] mem_addr_o;
  logic [7:0] mem_data_i;
  logic rsp_valid_o;
  logic rsp_ready_i;
  logic [7:0] rsp_data_o;
  logic rsp_sw_o;
  logic rsp_last_o;
  int mismatches = 0;
  int n_tests = 0;

  // Free-running clock of 4 ns.
  always #2 clk_i = ~clk_i;

  str_top #(.DEPTH(FIFO_DEPTH)) dut (.clk_i(clk_i), .srst_i(srst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_kind_i(cmd_kind_i), .cmd_tag_i(cmd_tag_i),
    .cmd_file_i(cmd_file_i), .cmd_le_i(cmd_le_i),
    .access_ok_i(access_ok_i), .proactive_i(proactive_i),
    .dir_wr_i(dir_wr_i), .dir_idx_i(dir_idx_i), .dir_valid_i(dir_valid_i),
    .dir_file_i(dir_file_i), .dir_tag_i(dir_tag_i),
    .dir_start_i(dir_start_i), .dir_len_i(dir_len_i),
    .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i),
    .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i),
    .rsp_data_o(rsp_data_o), .rsp_sw_o(rsp_sw_o), .rsp_last_o(rsp_last_o));

  str_env_model u_env (.clk_i(clk_i), .stall_i(stall),
    .mem_addr_i(mem_addr_o), .mem_data_o(mem_data_i),
    .rsp_ready_o(rsp_ready_i));

  // Report one mismatch and count it.
  task automatic fail(string m);
    mismatches++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic give_verdict();
    $display("%0d comparisons, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_byte(logic [8:0] got, logic [8:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("byte %h, expected %h", got, exp));
  endtask

  // Status word compare; an unknown word never passes.
  task automatic chk_sw(logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("status %h, expected %h", got, exp));
  endtask

  // Byte count of one response, status bytes included.
  task automatic chk_len(int got, int exp);
    n_tests++;
    if (got != exp) fail($sformatf("%0d bytes, expected %0d", got, exp));
  endtask

  // Length of the next segment: what is left, capped by Le (0 is 256).
  function automatic int exp_n(int rem, logic [7:0] le);
    int cap;
    cap = (le == 8'h00) ? 256 : int'(le);
    return (rem < cap) ? rem : cap;
  endfunction

  // One command, offered only while ready; a gap edge keeps strobes clean.
  task automatic send(logic [2:0] k, logic [7:0] tag, logic [7:0] file,
                      logic [7:0] le);
    int i;
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (cmd_ready_o !== 1'b1 && i < 300);
    if (i >= 300) begin
      fail("command port never ready");
      give_verdict();
    end
    cmd_kind_i = k;
    cmd_tag_i = tag;
    cmd_file_i = file;
    cmd_le_i = le;
    cmd_valid_i = 1'b1;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
  endtask

  // Retrieval command; collects the whole answer and compares it.
  task automatic retr(logic [2:0] k, logic [7:0] tag, logic [7:0] le,
                      logic [7:0] start, int n, logic [15:0] sw);
    logic [8:0] b[$];
    int i;
    send(k, tag, 8'h00, le);
    for (i = 0; i < 3000; i++) begin
      @(posedge clk_i);
      if (rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1) begin
        b.push_back({rsp_sw_o, rsp_data_o});
        if (rsp_last_o === 1'b1) break;
      end
    end
    if (i >= 3000) begin
      fail("response never ended");
      give_verdict();
    end
    chk_len(b.size(), n + 2);
    if (b.size() == n + 2) begin
      for (i = 0; i < n; i++) begin
        chk_byte(b[i], {1'b0, u_env.mem[8'(start + i)]});
      end
      if (b[n][8] !== 1'b1 || b[n + 1][8] !== 1'b1) begin
        fail("status flag");
      end
      chk_sw({b[n][7:0], b[n + 1][7:0]}, sw);
    end
    @(negedge clk_i);
  endtask

  task automatic dir(logic [1:0] idx, logic [7:0] file, logic [7:0] tag,
                     logic [15:0] start, logic [15:0] len);
    @(negedge clk_i);
    dir_idx_i = idx;
    dir_file_i = file;
    dir_tag_i = tag;
    dir_start_i = start;
    dir_len_i = len;
    dir_wr_i = 1'b1;
    @(negedge clk_i);
    dir_wr_i = 1'b0;
  endtask

  // Main sequence; object a2 is 40 bytes at 20h, so segments stay short.
  initial begin
    int off;
    int n;
    logic [7:0] le;
    logic [2:0] k;
    void'($urandom(82));
    for (int i = 0; i < 256; i++) u_env.mem[i] = 8'($urandom);
    u_env.mem[8'h10] = 8'h81;
    u_env.mem[8'h11] = 8'h02;
    u_env.mem[8'h12] = 8'h01;
    u_env.mem[8'h13] = 8'h02;
    u_env.mem[8'h80] = 8'h83;
    u_env.mem[8'h81] = 8'h00;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    dir(2'h0, 8'h01, 8'h81, 16'h0010, 16'h0004);
    dir(2'h1, 8'h01, 8'ha2, 16'h0020, 16'h0028);
    dir(2'h2, 8'h01, 8'h83, 16'h0080, 16'h0002);
    dir(2'h3, 8'h02, 8'h81, 16'h0090, 16'h0003);
    send(CMD_SEL, 8'h00, 8'h01, 8'h00);
    retr(CMD_FIRST, 8'h81, 8'h00, 8'h10, 0, SW_SEC);
    access_ok_i = 1'b1;
    retr(CMD_FIRST, 8'h81, 8'h00, 8'h10, 4, SW_OK);
    retr(CMD_NEXT, 8'h00, 8'h00, 8'h00, 0, SW_BAD_P1P2);
    send(CMD_SEL, 8'h00, 8'h01, 8'h00);
    retr(CMD_NEXT, 8'h00, 8'h00, 8'h00, 0, SW_NO_TAG);
    $display("test basic done");
    retr(CMD_FIRST, 8'ha2, 8'h10, 8'h20, 16, SW_MORE);
    send(CMD_OK, 8'h00, 8'h00, 8'h00);
    retr(CMD_NEXT, 8'h00, 8'h10, 8'h30, 16, SW_MORE);
    retr(CMD_RETX, 8'h00, 8'h00, 8'h30, 16, SW_MORE);
    send(CMD_ERR, 8'h00, 8'h00, 8'h00);
    retr(CMD_RETX, 8'h00, 8'h00, 8'h00, 0, SW_NO_RETX);
    retr(CMD_NEXT, 8'h00, 8'h00, 8'h40, 8, SW_OK);
    retr(CMD_RETX, 8'h00, 8'h00, 8'h40, 8, SW_OK);
    retr(CMD_NEXT, 8'h00, 8'h00, 8'h00, 0, SW_BAD_P1P2);
    $display("test interleave done");
    retr(CMD_FIRST, 8'ha2, 8'h10, 8'h20, 16, SW_MORE);
    retr(CMD_FIRST, 8'ha2, 8'h10, 8'h20, 16, SW_MORE);
    send(CMD_TAG, 8'h00, 8'h00, 8'h00);
    retr(CMD_NEXT, 8'h00, 8'h00, 8'h00, 0, SW_NO_TAG);
    proactive_i = 1'b1;
    retr(CMD_FIRST, 8'ha2, 8'h27, 8'h20, 39, SW_MORE_PRO);
    proactive_i = 1'b0;
    retr(CMD_NEXT, 8'h00, 8'h01, 8'h47, 1, SW_OK);
    retr(CMD_FIRST, 8'h83, 8'h00, 8'h80, 2, SW_OK);
    retr(CMD_FIRST, 8'h86, 8'h00, 8'h00, 0, SW_NOT_FOUND);
    retr(CMD_FIRST, 8'ha2, 8'h10, 8'h20, 16, SW_MORE);
    send(CMD_SEL, 8'h00, 8'h02, 8'h00);
    retr(CMD_NEXT, 8'h00, 8'h00, 8'h00, 0, SW_NO_TAG);
    retr(CMD_FIRST, 8'h81, 8'h00, 8'h90, 3, SW_OK);
    $display("test abort done");
    // The sink stops long enough for the buffer to fill and refuse.
    send(CMD_SEL, 8'h00, 8'h01, 8'h00);
    fork
      retr(CMD_FIRST, 8'ha2, 8'h00, 8'h20, 40, SW_OK);
      begin
        stall = 1'b1;
        repeat (40) @(negedge clk_i);
        stall = 1'b0;
      end
    join
    $display("test stall done");
    // Random Le: first-block, then next-block while more data comes back.
    repeat (6) begin
      off = 0;
      k = CMD_FIRST;
      while (off < 40) begin
        le = 8'($urandom_range(45, 1));
        n = exp_n(40 - off, le);
        retr(k, 8'ha2, le, 8'(8'h20 + off), n,
             (off + n < 40) ? SW_MORE : SW_OK);
        off += n;
        k = CMD_NEXT;
      end
    end
    $display("test random done");
    // A cleared directory entry must no longer be found.
    dir_valid_i = 1'b0;
    dir(2'h2, 8'h01, 8'h83, 16'h0080, 16'h0002);
    retr(CMD_FIRST, 8'h83, 8'h00, 8'h00, 0, SW_NOT_FOUND);
    dir_valid_i = 1'b1;
    $display("test directory done");
    give_verdict();
  end
endmodule
